/* File: gear_shift_partner.sv */
// Model of speed sensors, throttle pedal and shift lever
`timescale 1ns/1ps
module gear_shift_partner
  import gear_shift_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Commanded conditions
  input  wire logic [SW-1:0] turbine,
  input  wire logic [SW-1:0] outSpeed,
  input  wire logic [7:0]    throttle,
  input  wire dir_t          dir,
  input  wire logic [GW-1:0] lvGear,
  input  wire logic          autoSel,
  // Sensed values
  output sense_t             sense,
  output lever_t             lever
);
  // Sensors and lever refresh once a cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sense <= '0;
      lever <= '0;
    end else begin
      sense <= '{turbine, outSpeed, throttle};
      lever <= '{dir, lvGear, autoSel};
    end
  end
endmodule

/* File: gear_shift_pkg.sv */
// Shared constants and types for the range gear decision block
package gear_shift_pkg;

  localparam int GEARS = 4;
  localparam int GW    = 2;
  localparam int SW    = 16;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_ZONE  = 8'h08;
  localparam logic [7:0] OFS_TLIM  = 8'h0C;
  localparam logic [7:0] OFS_OLIM  = 8'h10;
  localparam logic [7:0] OFS_RATIO = 8'h20;
  localparam logic [7:0] OFS_HALF  = 8'h30;
  localparam logic [7:0] OFS_FULL  = 8'h40;

  // Field positions
  localparam int CTRL_CAP_BIT = 0;
  localparam int CTRL_LOW_LSB = 2;
  localparam int RATIO_FRAC   = 8;

  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ZONE_RST  = 32'h0000_C060;
  localparam logic [31:0] TLIM_RST  = 32'h0AF0_0BB8;
  localparam logic [31:0] OLIM_RST  = 32'h0AF0_0BB8;
  localparam logic [15:0] RATIO_RST = 16'h0100;
  localparam logic [31:0] PTS_RST   = 32'h0578_07D0;

  typedef enum logic [1:0] {
    DIR_N = 2'b00,
    DIR_F = 2'b01,
    DIR_R = 2'b10
  } dir_t;

  typedef enum logic [1:0] {
    ZONE_LOW  = 2'b00,
    ZONE_HALF = 2'b01,
    ZONE_FULL = 2'b10
  } zone_t;

  typedef struct packed {
    logic [SW-1:0] turbine;
    logic [SW-1:0] outSpeed;
    logic [7:0]    throttle;
  } sense_t;

  typedef struct packed {
    dir_t          dir;
    logic [GW-1:0] gear;
    logic          autoSel;
  } lever_t;

endpackage

/* File: gear_shift_protection.sv */
// Range gear decision with downshift and overspeed protections
`timescale 1ns/1ps
module gear_shift_protection
  import gear_shift_pkg::*;
(
  // Clock, reset, enable
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          clkEn,
  // Control tick and sensed inputs
  input  wire logic          tick,
  input  wire sense_t        sense,
  input  wire lever_t        lever,
  // Wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Gear and lamp outputs
  output logic      [GW-1:0] gearSel,
  output logic               shiftPulse,
  output logic               warnLamp,
  output logic               downPending
);

  logic [31:0]   ctrlReg;
  logic [31:0]   zoneReg;
  logic [31:0]   tlimReg;
  logic [31:0]   olimReg;
  logic [15:0]   ratio   [GEARS];
  logic [31:0]   halfPts [GEARS];
  logic [31:0]   fullPts [GEARS];
  logic          osArmed;
  logic          wbReq;
  logic          wbWr;
  logic [31:0]   next_dat;
  zone_t         zone;
  logic [GW-1:0] lowGear;
  logic [31:0]   prod;
  logic [SW-1:0] predicted;
  logic          downOk;
  logic [31:0]   pts;
  logic [SW-1:0] upPt;
  logic [SW-1:0] dnPt;
  logic [GW-1:0] ceiling;
  logic [GW-1:0] lowest;
  logic [SW-1:0] osSpeed;
  logic [SW-1:0] osLim;
  logic [SW-1:0] osWarn;
  logic          osUp;
  logic          warnNear;
  logic          autoUp;
  logic          autoDn;
  logic          upReq;
  logic          downReq;
  logic [GW-1:0] next_gear;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] din,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr  = wbReq & wb_we_i;

  // Bus answer, one cycle after the request is seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn) begin
      wb_ack_o <= wbReq;
      wb_dat_o <= next_dat;
    end
  end

  // Read decode; unmapped reads answer zero
  always_comb begin
    next_dat = 32'h0000_0000;
    if (wb_adr_i == OFS_CTRL) begin
      next_dat = ctrlReg;
    end else if (wb_adr_i == OFS_STAT) begin
      next_dat = {24'h000000, osArmed, downPending, warnLamp,
                  zone, 1'b0, gearSel};
    end else if (wb_adr_i == OFS_ZONE) begin
      next_dat = zoneReg;
    end else if (wb_adr_i == OFS_TLIM) begin
      next_dat = tlimReg;
    end else if (wb_adr_i == OFS_OLIM) begin
      next_dat = olimReg;
    end else if (wb_adr_i[7:4] == OFS_RATIO[7:4]) begin
      next_dat = {16'h0000, ratio[wb_adr_i[3:2]]};
    end else if (wb_adr_i[7:4] == OFS_HALF[7:4]) begin
      next_dat = halfPts[wb_adr_i[3:2]];
    end else if (wb_adr_i[7:4] == OFS_FULL[7:4]) begin
      next_dat = fullPts[wb_adr_i[3:2]];
    end
  end

  // Global configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlReg <= CTRL_RST;
      zoneReg <= ZONE_RST;
      tlimReg <= TLIM_RST;
      olimReg <= OLIM_RST;
    end else if (clkEn && wbWr) begin
      if (wb_adr_i == OFS_CTRL) begin
        ctrlReg <= merge(ctrlReg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_ZONE) begin
        zoneReg <= merge(zoneReg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_TLIM) begin
        tlimReg <= merge(tlimReg, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_OLIM) begin
        olimReg <= merge(olimReg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Per-gear ratio and shift point registers
  for (genvar g = 0; g < GEARS; g++) begin : g_gear
    localparam logic [1:0] IDX = 2'(g);
    logic [31:0] ratioWide;
    assign ratioWide = merge({16'h0000, ratio[g]}, wb_dat_i, wb_sel_i);
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ratio[g]   <= RATIO_RST;
        halfPts[g] <= PTS_RST;
        fullPts[g] <= PTS_RST;
      end else if (clkEn && wbWr && wb_adr_i[3:2] == IDX) begin
        if (wb_adr_i[7:4] == OFS_RATIO[7:4]) begin
          ratio[g] <= ratioWide[15:0];
        end else if (wb_adr_i[7:4] == OFS_HALF[7:4]) begin
          halfPts[g] <= merge(halfPts[g], wb_dat_i, wb_sel_i);
        end else if (wb_adr_i[7:4] == OFS_FULL[7:4]) begin
          fullPts[g] <= merge(fullPts[g], wb_dat_i, wb_sel_i);
        end
      end
    end
  end

  // Throttle zone classification
  always_comb begin
    if (sense.throttle >= zoneReg[15:8]) begin
      zone = ZONE_FULL;
    end else if (sense.throttle >= zoneReg[7:0]) begin
      zone = ZONE_HALF;
    end else begin
      zone = ZONE_LOW;
    end
  end

  // Predicted turbine speed in the next lower gear
  assign lowGear = (gearSel == '0) ? '0 : gearSel - 2'd1;
  assign prod    = sense.outSpeed * ratio[lowGear];
  assign predicted = (prod[31:24] != 8'h00) ? 16'hFFFF
                   : prod[23:8];
  assign downOk  = predicted <= tlimReg[15:0];

  // Shift points of the current gear: full points in the full zone, half points in the low and half zones
  assign pts  = (zone == ZONE_FULL) ? fullPts[gearSel]
              : halfPts[gearSel];
  assign upPt = pts[15:0];
  assign dnPt = pts[31:16];

  // Overspeed ceiling, optionally capped at the lever gear
  assign ceiling = ctrlReg[CTRL_CAP_BIT] ? lever.gear
                 : 2'(GEARS - 1);
  assign lowest  = ctrlReg[CTRL_LOW_LSB +: GW];

  // Neutral watches output speed, forward/reverse turbine speed
  always_comb begin
    if (lever.dir == DIR_N) begin
      osSpeed = sense.outSpeed;
      osLim   = olimReg[15:0];
      osWarn  = olimReg[31:16];
    end else begin
      osSpeed = sense.turbine;
      osLim   = tlimReg[15:0];
      osWarn  = tlimReg[31:16];
    end
  end

  assign warnNear = osSpeed >= osWarn;
  assign osUp = osArmed && osSpeed >= osLim
              && gearSel < ceiling;

  // Automatic decisions from the zone speed points, plus a forced upshift while below both the lowest gear and the lever gear
  always_comb begin
    autoUp = 1'b0;
    autoDn = 1'b0;
    if (gearSel < lowest && gearSel < lever.gear) begin
      autoUp = 1'b1;
    end else if (gearSel > lever.gear) begin
      autoDn = sense.turbine < dnPt;
    end else if (zone != ZONE_LOW) begin
      autoUp = sense.turbine >= upPt
             && gearSel < lever.gear;
      autoDn = sense.turbine < dnPt
             && gearSel > lowest;
    end
  end

  assign upReq   = lever.autoSel ? autoUp
                 : (gearSel < lever.gear);
  assign downReq = lever.autoSel ? autoDn
                 : (gearSel > lever.gear);

  // Priority: overspeed up, protected down, normal up
  always_comb begin
    next_gear = gearSel;
    if (osUp) begin
      next_gear = gearSel + 2'd1;
    end else if (downReq && downOk) begin
      next_gear = gearSel - 2'd1;
    end else if (upReq && !downReq) begin
      next_gear = gearSel + 2'd1;
    end
  end

  // Gear state, updated once per tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gearSel    <= '0;
      shiftPulse <= 1'b0;
    end else if (clkEn) begin
      shiftPulse <= 1'b0;
      if (tick) begin
        gearSel    <= next_gear;
        shiftPulse <= next_gear != gearSel;
      end
    end
  end

  // Re-arm overspeed only after speed falls below limit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      osArmed <= 1'b1;
    end else if (clkEn && tick) begin
      if (osUp) begin
        osArmed <= 1'b0;
      end else if (osSpeed < osLim) begin
        osArmed <= 1'b1;
      end
    end
  end

  // Warning lamp and withheld downshift
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      downPending <= 1'b0;
      warnLamp    <= 1'b0;
    end else if (clkEn && tick) begin
      downPending <= downReq && !downOk && !osUp;
      warnLamp    <= (downReq && !downOk)
                   || warnNear;
    end
  end

endmodule

/* File: gear_shift_protection_asserts.sv */
// Checker for the range gear decision block
`timescale 1ns/1ps
module gear_shift_protection_asserts
  import gear_shift_pkg::*;
(
  // Clock and control
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          clkEn,
  input wire logic          tick,
  // Bus handshake
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  // Decisions
  input wire logic [GW-1:0] gearSel,
  input wire logic          shiftPulse,
  input wire logic          warnLamp,
  input wire logic          downPending
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
  endsequence
  sequence tickIn;
    tick && clkEn;
  endsequence
  ack_resp_a: assert property (wbReq |=> wb_ack_o)
    else $error("bus ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  gear_hold_a: assert property (!(tick && clkEn) |=> $stable(gearSel))
    else $error("gear moved without tick");
  lamp_hold_a: assert property (!(tick && clkEn) |=>
    $stable(warnLamp) && $stable(downPending)) else $error("lamp moved");
  pulse_match_a: assert property (tickIn |=>
    shiftPulse == (gearSel != $past(gearSel))) else $error("pulse wrong");
  pulse_cause_a: assert property (shiftPulse |-> $past(tick && clkEn))
    else $error("pulse without tick");
  one_step_a: assert property (tickIn |=>
    {1'b0, gearSel} + 3'd1 >= {1'b0, $past(gearSel)} &&
    {1'b0, gearSel} <= {1'b0, $past(gearSel)} + 3'd1)
    else $error("gear moved more than one");
  pend_lamp_a: assert property (downPending |-> warnLamp)
    else $error("withheld shift without lamp");
endmodule
bind gear_shift_protection gear_shift_protection_asserts u_chk (.mclk,
  .rst, .clkEn, .tick, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .gearSel,
  .shiftPulse, .warnLamp, .downPending);

/* File: testbench.sv */
// Self-checking bench for the range gear decision block
`timescale 1ns/1ps
module testbench import gear_shift_pkg::*;;
  logic          mclk = 0, rst = 1, clkEn = 1, tick = 0;
  logic          cyc = 0, stb = 0, we = 0, autoSel = 0;
  logic [3:0]    sel = '0;
  logic [7:0]    adr = '0, thr = '0;
  logic [31:0]   dw = '0, dr, rd;
  logic          ack, pulse, lamp, pend;
  logic [GW-1:0] gear, lvGear = '0, lastG = '0;
  logic [SW-1:0] trb = '0, os = '0;
  dir_t          dir = DIR_N;
  sense_t        sense;
  lever_t        lever;
  int            mismatches = 0, check_count = 0, cycN = 0;
  gear_shift_partner u_env (.mclk, .rst, .turbine(trb), .outSpeed(os),
    .throttle(thr), .dir, .lvGear, .autoSel, .sense, .lever);
  gear_shift_protection u_dut (.mclk, .rst, .clkEn, .tick, .sense, .lever,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .gearSel(gear), .shiftPulse(pulse), .warnLamp(lamp), .downPending(pend));
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) if (++cycN == 5000) begin
    mismatches++;
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wbw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    @(posedge mclk);
    {cyc, stb, we, adr, dw, sel} <= {3'b111, a, d, s};
    do @(posedge mclk); while (ack !== 1'b1);
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wbr(input logic [7:0] a);
    @(posedge mclk);
    {cyc, stb, we, adr, sel} <= {3'b110, a, 4'hF};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dr;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic step(input logic [15:0] t, o, input logic [7:0] h,
                      input logic [1:0] g, input logic l);
    {trb, os, thr} <= {t, o, h};
    @(posedge mclk);
    tick <= 1;
    @(posedge mclk);
    tick <= 0;
    @(negedge mclk);
    chk(32'(gear), 32'(g));
    chk(32'(lamp), 32'(l));
    chk(32'(pulse), 32'(g != lastG));
    lastG = g;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 0;
    wbr(OFS_ZONE);
    chk(rd, ZONE_RST);
    wbr(OFS_TLIM);
    chk(rd, TLIM_RST);
    wbr(8'h80);
    chk(rd, 32'h0);
    wbw(OFS_STAT, 32'hFF);
    wbr(OFS_STAT);
    chk(rd & 32'h7F, 32'h0);
    wbw(OFS_ZONE, 32'h70, 4'h1);
    wbr(OFS_ZONE);
    chk(rd, 32'hC070);
    wbw(OFS_ZONE, ZONE_RST);
    $display("test registers done");
    dir <= DIR_F;
    {lvGear, autoSel} <= {2'd3, 1'b1};
    step(2100, 0, 8'h10, 0, 0);
    step(2100, 0, 8'h80, 1, 0);
    step(1500, 0, 8'h80, 1, 0);
    for (int g = 0; g < GEARS; g++) wbw(OFS_FULL + 8'(4 * g), 32'h0578_0900);
    step(2100, 0, 8'hD0, 1, 0);
    step(2400, 0, 8'hD0, 2, 0);
    step(1300, 0, 8'h80, 1, 0);
    $display("test automatic done");
    {lvGear, autoSel} <= 3'b000;
    for (int g = 0; g < GEARS; g++) wbw(OFS_RATIO + 8'(4 * g), 32'h0200);
    step(1000, 2000, 0, 1, 1);
    chk(32'(pend), 32'h1);
    step(1000, 1500, 0, 0, 0);
    chk(32'(pend), 32'h0);
    step(3000, 3100, 0, 1, 1);
    step(3000, 3100, 0, 1, 1);
    step(2900, 3100, 0, 1, 1);
    step(3000, 3100, 0, 2, 1);
    step(2900, 3100, 0, 2, 1);
    step(3000, 3100, 0, 3, 1);
    step(2900, 3100, 0, 3, 1);
    step(3000, 3100, 0, 3, 1);
    for (int g = 2; g >= 0; g--) step(1000, 1000, 0, 2'(g), 0);
    $display("test forward overspeed done");
    dir <= DIR_N;
    wbw(OFS_CTRL, 32'h1);
    step(0, 2900, 0, 0, 1);
    step(0, 3000, 0, 0, 1);
    wbw(OFS_CTRL, 32'h0);
    for (int g = 1; g <= 3; g++) begin
      step(0, 2900, 0, 2'(g - 1), 1);
      step(0, 3000, 0, 2'(g), 1);
    end
    step(0, 2900, 0, 3, 1);
    step(0, 3000, 0, 3, 1);
    $display("test neutral overspeed done");
    clkEn <= 0;
    step(0, 0, 0, 3, 1);
    clkEn <= 1;
    step(0, 0, 0, 2, 0);
    step(0, 0, 0, 1, 0);
    dir <= DIR_F;
    {lvGear, autoSel} <= {2'd3, 1'b1};
    wbw(OFS_CTRL, 32'h8);
    step(0, 0, 0, 2, 0);
    step(3000, 0, 0, 3, 1);
    $display("test limits done");
    results();
  end
endmodule
